// ===== src/axwa_pkg.sv
// Purpose: shared widths, encodings and states for the write address channel.
// Assumes: one bus clock, synchronous active-low reset.
// Notes: AXI3-style field widths.
package axwa_pkg;
   localparam int ID_W = 4;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 4;
   localparam int SIZE_W = 3;
   localparam int BURST_W = 2;
   localparam int LOCK_W = 2;
   localparam int CACHE_W = 4;
   localparam int PROT_W = 3;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   localparam logic [4:0] BEATS_RST = 5'h00;
   localparam logic [31:0] ADDR_RST = 32'h00000000;

   typedef enum logic [1:0] {
      AXWA_IDLE = 2'b01,
      AXWA_BUSY = 2'b10
   } axwa_state_t;

   typedef enum logic [1:0] {
      AXWA_M_IDLE = 2'b01,
      AXWA_M_SEND = 2'b10
   } axwa_mstate_t;
endpackage

// ===== src/axwa_if.sv
// Purpose: write address channel wires between master and slave.
// Assumes: both ends on clk_in.
// Notes: no clocking block; the bench binds the ends.
`timescale 1ns/1ps
interface axwa_if;
   logic [axwa_pkg::ID_W-1:0] awid;
   logic [axwa_pkg::ADDR_W-1:0] awaddr;
   logic [axwa_pkg::LEN_W-1:0] awlen;
   logic [axwa_pkg::SIZE_W-1:0] awsize;
   logic [axwa_pkg::BURST_W-1:0] awburst;
   logic [axwa_pkg::LOCK_W-1:0] awlock;
   logic [axwa_pkg::CACHE_W-1:0] awcache;
   logic [axwa_pkg::PROT_W-1:0] awprot;
   logic awvalid;
   logic awready;

   modport master (
      output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
      input awready
   );
   modport slave (
      input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
      output awready
   );
endinterface

// ===== src/axwa_master.sv
// Purpose: master end; turns a user request into one write address handshake.
// Assumes: user holds req fields while req_valid_in is high and req_ready_out low.
// Notes: fields are latched at acceptance so the bus stays stable.
`timescale 1ns/1ps
module axwa_master (
   input wire logic clk_in,
   input wire logic nrst_in,
   axwa_if.master aw,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [axwa_pkg::ID_W-1:0] req_id_in,
   input wire logic [axwa_pkg::ADDR_W-1:0] req_addr_in,
   input wire logic [axwa_pkg::LEN_W-1:0] req_len_in,
   input wire logic [axwa_pkg::SIZE_W-1:0] req_size_in,
   input wire logic [axwa_pkg::BURST_W-1:0] req_burst_in,
   input wire logic [axwa_pkg::LOCK_W-1:0] req_lock_in,
   input wire logic [axwa_pkg::CACHE_W-1:0] req_cache_in,
   input wire logic [axwa_pkg::PROT_W-1:0] req_prot_in,
   output logic done_out
);
   typedef struct packed {
      axwa_pkg::axwa_mstate_t st;
      logic [axwa_pkg::ID_W-1:0] id;
      logic [axwa_pkg::ADDR_W-1:0] addr;
      logic [axwa_pkg::LEN_W-1:0] len;
      logic [axwa_pkg::SIZE_W-1:0] size;
      logic [axwa_pkg::BURST_W-1:0] burst;
      logic [axwa_pkg::LOCK_W-1:0] lock;
      logic [axwa_pkg::CACHE_W-1:0] cache;
      logic [axwa_pkg::PROT_W-1:0] prot;
      logic done;
   } axwa_mst_t;

   axwa_mst_t s_q;
   axwa_mst_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         axwa_pkg::AXWA_M_IDLE:
         begin
            if (req_valid_in)
            begin
               s_d.st = axwa_pkg::AXWA_M_SEND;
               s_d.id = req_id_in;
               s_d.addr = req_addr_in;
               s_d.len = req_len_in;
               s_d.size = req_size_in;
               s_d.burst = req_burst_in;
               s_d.lock = req_lock_in;
               s_d.cache = req_cache_in;
               s_d.prot = req_prot_in;
            end
         end
         axwa_pkg::AXWA_M_SEND:
         begin
            if (aw.awready)
            begin
               s_d.st = axwa_pkg::AXWA_M_IDLE;
               s_d.done = 1'b1;
            end
         end
      endcase
      if (!nrst_in)
      begin
         s_d = '0;
         s_d.st = axwa_pkg::AXWA_M_IDLE;
      end
   end

   always_ff @(posedge clk_in)
   begin
      s_q <= s_d;
   end

   assign req_ready_out = (s_q.st == axwa_pkg::AXWA_M_IDLE);
   assign done_out = s_q.done;
   assign aw.awvalid = (s_q.st == axwa_pkg::AXWA_M_SEND);
   assign aw.awid = s_q.id;
   assign aw.awaddr = s_q.addr;
   assign aw.awlen = s_q.len;
   assign aw.awsize = s_q.size;
   assign aw.awburst = s_q.burst;
   assign aw.awlock = s_q.lock;
   assign aw.awcache = s_q.cache;
   assign aw.awprot = s_q.prot;
endmodule

// ===== src/axwa_slave.sv
// Purpose: slave end; accepts a write address, then walks beat addresses.
// Assumes: the data side pulses beat_in once per accepted data beat.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// - Master sends 4-bit tag per address.
// - Later beat addresses derived from controls.
// - Length field gives beats; slave expects them.
// - Size gives beat width; strobes pick lanes.
// - Next address from burst type and size.
// - Master supplies 2-bit lock type.
// - Master supplies 4-bit cache attributes.
// - Master supplies 3-bit protection field.
// - Valid high only when address available.
// - Master holds fields until ready seen.
// - Ready high only when slave can accept.
// - Slave waits valid, accepts with ready.
// - Data tag equals address tag.
`timescale 1ns/1ps
module axwa_slave #(
   parameter int ID_W = axwa_pkg::ID_W
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   axwa_if.slave aw,
   input wire logic beat_in,
   output logic busy_out,
   output logic accept_out,
   output logic [ID_W-1:0] id_out,
   output logic [axwa_pkg::ADDR_W-1:0] beat_addr_out,
   output logic [axwa_pkg::SIZE_W-1:0] size_out,
   output logic [axwa_pkg::LOCK_W-1:0] lock_out,
   output logic [axwa_pkg::CACHE_W-1:0] cache_out,
   output logic [axwa_pkg::PROT_W-1:0] prot_out,
   output logic last_out
);
   typedef struct packed {
      axwa_pkg::axwa_state_t st;
      logic [ID_W-1:0] id;
      logic [axwa_pkg::ADDR_W-1:0] addr;
      logic [axwa_pkg::LEN_W-1:0] len;
      logic [axwa_pkg::SIZE_W-1:0] size;
      logic [axwa_pkg::BURST_W-1:0] burst;
      logic [axwa_pkg::LOCK_W-1:0] lock;
      logic [axwa_pkg::CACHE_W-1:0] cache;
      logic [axwa_pkg::PROT_W-1:0] prot;
      logic [4:0] left;
      logic accept;
   } axwa_sst_t;

   axwa_sst_t s_q;
   axwa_sst_t s_d;

   // Next beat address; wrap boundary is beats times beat bytes
   function automatic logic [31:0] axwa_next(input logic [31:0] a, input logic [2:0] sz,
                                             input logic [1:0] bt, input logic [3:0] ln);
      logic [31:0] step;
      logic [31:0] span;
      logic [31:0] inc;
      step = 32'h00000001 << sz;
      span = ({28'h0000000, ln} + 32'h00000001) << sz;
      inc = a + step;
      axwa_next = a;
      if (bt == axwa_pkg::BURST_INCR)
         axwa_next = inc;
      else if (bt == axwa_pkg::BURST_WRAP)
         axwa_next = (a & ~(span - 32'h00000001)) | (inc & (span - 32'h00000001));
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.accept = 1'b0;
      unique case (s_q.st)
         axwa_pkg::AXWA_IDLE:
         begin
            if (aw.awvalid)
            begin
               s_d.st = axwa_pkg::AXWA_BUSY;
               s_d.accept = 1'b1;
               s_d.id = aw.awid;
               s_d.addr = aw.awaddr;
               s_d.len = aw.awlen;
               s_d.size = aw.awsize;
               s_d.burst = aw.awburst;
               s_d.lock = aw.awlock;
               s_d.cache = aw.awcache;
               s_d.prot = aw.awprot;
               s_d.left = {1'b0, aw.awlen} + 5'h01;
            end
         end
         axwa_pkg::AXWA_BUSY:
         begin
            if (beat_in)
            begin
               s_d.addr = axwa_next(s_q.addr, s_q.size, s_q.burst, s_q.len);
               s_d.left = s_q.left - 5'h01;
               if (s_q.left == 5'h01)
                  s_d.st = axwa_pkg::AXWA_IDLE;
            end
         end
      endcase
      if (!nrst_in)
      begin
         s_d = '0;
         s_d.st = axwa_pkg::AXWA_IDLE;
         s_d.addr = axwa_pkg::ADDR_RST;
         s_d.left = axwa_pkg::BEATS_RST;
      end
   end

   always_ff @(posedge clk_in)
   begin
      s_q <= s_d;
   end

   // ready only when idle
   // Idle slave has no pending burst, so one address at a time
   assign aw.awready = (s_q.st == axwa_pkg::AXWA_IDLE);
   assign busy_out = (s_q.st == axwa_pkg::AXWA_BUSY);
   assign accept_out = s_q.accept;
   assign id_out = s_q.id;
   assign beat_addr_out = s_q.addr;
   assign size_out = s_q.size;
   assign lock_out = s_q.lock;
   assign cache_out = s_q.cache;
   assign prot_out = s_q.prot;
   assign last_out = busy_out && (s_q.left == 5'h01);
endmodule

// ===== verification/axwa_chk.sv
// Purpose: handshake checks on the write address channel wires.
// Assumes: one clock, synchronous active-low reset.
// Notes: sees only the interface signals.
`timescale 1ns/1ps
module axwa_chk (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [3:0] awid,
   input wire logic [31:0] awaddr,
   input wire logic [3:0] awlen,
   input wire logic [2:0] awsize,
   input wire logic [1:0] awburst,
   input wire logic [1:0] awlock,
   input wire logic [3:0] awcache,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   input wire logic awready
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_ahold; awvalid && !awready |=> awvalid && $stable(awaddr); endproperty
   a_ahold: assert property (p_ahold) else $error("address dropped");
   property p_chold; awvalid && !awready |=> $stable({awid, awlen, awsize, awburst,
      awlock, awcache, awprot}); endproperty
   a_chold: assert property (p_chold) else $error("control moved");
   property p_vdrop; awvalid && awready |=> !awvalid; endproperty
   a_vdrop: assert property (p_vdrop) else $error("valid after handshake");
   property p_rdrop; awvalid && awready |=> !awready; endproperty
   a_rdrop: assert property (p_rdrop) else $error("ready while busy");
   property p_rcause; $fell(awready) |-> $past(awvalid); endproperty
   a_rcause: assert property (p_rcause) else $error("ready fell unasked");
   property p_rstay; !awvalid && awready |=> awready; endproperty
   a_rstay: assert property (p_rstay) else $error("idle ready lost");
   property p_rst; $rose(nrst_in) |-> awready && !awvalid; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_take; $rose(awvalid) |-> ##[0:100] (awvalid && awready); endproperty
   a_take: assert property (p_take) else $error("address never taken");
endmodule

// ===== verification/axi_write_address_channel_slave_tb.sv
// Purpose: drives both ends of the write address channel and checks captures.
// Assumes: inputs change at the falling edge.
// Notes: beat addresses are predicted here from the burst rules.
`timescale 1ns/1ps
module axi_write_address_channel_slave_tb;
   logic clk_in = 1'h0;
   logic nrst_in = 1'h0;
   logic req_valid_in = 1'h0;
   logic beat_in = 1'h0;
   logic [3:0] id = 4'h0;
   logic [31:0] addr = 32'h0;
   logic [3:0] len = 4'h0;
   logic [2:0] sz = 3'h0;
   logic [1:0] bt = 2'h0;
   logic req_ready_out, done_out, busy_out, accept_out, last_out;
   logic [3:0] id_out, cache_out;
   logic [31:0] beat_addr_out;
   logic [2:0] size_out, prot_out;
   logic [1:0] lock_out;
   int err_count = 0;
   int tests_run = 0;
   always #2 clk_in = ~clk_in;
   axwa_if aw();
   axwa_master u_axwa_master (.clk_in(clk_in), .nrst_in(nrst_in), .aw(aw),
      .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_id_in(id),
      .req_addr_in(addr), .req_len_in(len), .req_size_in(sz), .req_burst_in(bt),
      .req_lock_in(id[1:0]), .req_cache_in(~id), .req_prot_in(sz), .done_out(done_out));
   axwa_slave u_axwa_slave (.clk_in(clk_in), .nrst_in(nrst_in), .aw(aw), .beat_in(beat_in),
      .busy_out(busy_out), .accept_out(accept_out), .id_out(id_out),
      .beat_addr_out(beat_addr_out), .size_out(size_out), .lock_out(lock_out),
      .cache_out(cache_out), .prot_out(prot_out), .last_out(last_out));
   axwa_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .awid(aw.awid), .awaddr(aw.awaddr),
      .awlen(aw.awlen), .awsize(aw.awsize), .awburst(aw.awburst), .awlock(aw.awlock),
      .awcache(aw.awcache), .awprot(aw.awprot), .awvalid(aw.awvalid),
      .awready(aw.awready));
   task automatic results();
      $display("mismatches %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(negedge clk_in);
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] a, input logic [3:0] l,
      input logic [2:0] s, input logic [1:0] b);
      logic [31:0] w;
      w = ({28'h0, l} + 32'h1) << s;
      if (b == axwa_pkg::BURST_INCR)
         return a + (32'h1 << s);
      // Wrap stays inside the aligned window of the whole burst
      if (b == axwa_pkg::BURST_WRAP)
         return (a & ~(w - 32'h1)) | ((a + (32'h1 << s)) & (w - 32'h1));
      return a;
   endfunction
   task automatic issue(input logic [3:0] i, input logic [31:0] a, input logic [3:0] l,
      input logic [2:0] s, input logic [1:0] b);
      check(req_ready_out, 32'h1);
      {id, addr, len, sz, bt} = {i, a, l, s, b};
      req_valid_in = 1'h1;
      tick();
      req_valid_in = 1'h0;
   endtask
   task automatic got(input logic [3:0] i, input logic [31:0] a, input logic [2:0] s);
      int n;
      n = 0;
      while (done_out !== 1'h1)
      begin
         tick();
         n++;
         if (n > 200)
         begin
            err_count++;
            results();
         end
      end
      check(accept_out, 32'h1);
      check({id_out, size_out, lock_out, cache_out, prot_out}, {i, s, i[1:0], ~i, s});
      check(beat_addr_out, a);
   endtask
   task automatic beats(input logic [31:0] a, input logic [3:0] l, input logic [2:0] s,
      input logic [1:0] b);
      for (int k = 0; k <= l; k++)
      begin
         check(beat_addr_out, a);
         check(last_out, 32'(k == l));
         beat_in = 1'h1;
         tick();
         beat_in = 1'h0;
         // Look before a waiting address can be taken at the next edge
         if (k == l)
            check({busy_out, aw.awready}, 32'h1);
         a = nxt(a, l, s, b);
         tick();
      end
   endtask
   task automatic xfer(input logic [3:0] i, input logic [31:0] a, input logic [3:0] l,
      input logic [2:0] s, input logic [1:0] b);
      issue(i, a, l, s, b);
      got(i, a, s);
      beats(a, l, s, b);
   endtask
   initial
   begin
      repeat (3) tick();
      nrst_in = 1'h1;
      xfer(4'h1, 32'h100, 4'h2, 3'h2, axwa_pkg::BURST_FIXED);
      xfer(4'h2, 32'h1F8, 4'hF, 3'h0, axwa_pkg::BURST_INCR);
      xfer(4'h3, 32'h34, 4'h3, 3'h2, axwa_pkg::BURST_WRAP);
      xfer(4'hC, 32'h202, 4'h1, 3'h1, 2'h3);
      issue(4'h5, 32'h40, 4'h1, 3'h2, axwa_pkg::BURST_INCR);
      got(4'h5, 32'h40, 3'h2);
      // Second address waits while the first burst is still open
      issue(4'hA, 32'h88, 4'h1, 3'h3, axwa_pkg::BURST_WRAP);
      repeat (5) tick();
      check({done_out, aw.awvalid, aw.awready}, 32'h2);
      beats(32'h40, 4'h1, 3'h2, axwa_pkg::BURST_INCR);
      got(4'hA, 32'h88, 3'h3);
      beats(32'h88, 4'h1, 3'h3, axwa_pkg::BURST_WRAP);
      results();
   end
   initial
   begin
      repeat (5000) @(posedge clk_in);
      err_count++;
      results();
   end
endmodule
